// ### hw/etc_pkg.sv
package etc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NCH = 8;
    localparam int CHW = 3;
    localparam int NDESC = 32;
    localparam int IW = 5;
    localparam int NSEQ = 256;
    localparam int SELW = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int DW = 32;

    // ------------------------------------------------------------------
    // Encodings and constants
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_REPEAT = 2'h1;
    localparam logic [1:0] MODE_BLOCK = 2'h2;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [31:0] STEP_BYTE = 32'h1;
    localparam logic [31:0] STEP_WORD = 32'h2;
    localparam logic [31:0] STEP_LONG = 32'h4;
    localparam logic [31:0] STEP_NONE = 32'h0;
    localparam logic [8:0] RPT_ONE = 9'h001;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [IW-1:0] IDX_ONE = 5'h01;

    // ------------------------------------------------------------------
    // Transfer description and bus command
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] size;
        logic chain;
        logic chain_zero;
        logic div;
        logic irq_en;
        logic src_inc;
        logic dst_inc;
        logic rpt_dst;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] rpt_start;
        logic [15:0] count;
        logic [8:0] rpt;
        logic [8:0] rpt_left;
    } etc_desc_t;

    typedef struct packed {
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } etc_bus_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_READ,
        ST_WRITE,
        ST_DONE
    } etc_state_t;

endpackage : etc_pkg

// ### hw/etc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module etc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (cnt != DEPTH[AW:0]);
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage needs no reset; only the pointers and the count do.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    // Pointers and count.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : etc_fifo
`default_nettype wire

// ### hw/etc_top.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - One channel per triggering interrupt source.
// - Normal mode: one transfer per activation.
// - Repeat mode reloads start address at size.
// - Repeat size reaches 256 transfers.
// - Block mode: whole block per activation.
// - Block size reaches 256 units.
// - Chaining runs several descriptions per request.
// - Chain always or only at count zero.
// - Sequences of descriptions, chosen by data.
// - Only one sequence trigger source.
// - Up to 256 sequences per trigger.
// - First transferred data selects the sequence.
// - Sequence may pause and resume next request.
// - Unit is byte, word or longword.
// - Processor interrupt when count is done.
// - Link event per transfer or block.
module etc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Activation requests from the interrupt controller
    input wire logic [etc_pkg::NCH-1:0] act_req,
    output logic [etc_pkg::NCH-1:0] act_ack,
    // Description and sequence table loading
    input wire logic cfg_we,
    input wire logic [etc_pkg::IW-1:0] cfg_idx,
    input wire etc_pkg::etc_desc_t cfg_desc,
    input wire logic seq_we,
    input wire logic [etc_pkg::SELW-1:0] seq_idx,
    input wire logic [etc_pkg::IW-1:0] seq_ptr,
    input wire logic seq_en,
    input wire logic [etc_pkg::CHW-1:0] seq_src_ch,
    // System bus master
    output logic bus_req,
    output etc_pkg::etc_bus_cmd_t bus_cmd,
    input wire logic bus_ack,
    input wire logic [etc_pkg::DW-1:0] bus_rdata,
    // Events
    output logic cpu_irq,
    output logic [etc_pkg::CHW-1:0] irq_ch,
    output logic link_evt,
    output logic busy
);
    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    etc_pkg::etc_desc_t pool [etc_pkg::NDESC];
    logic [etc_pkg::IW-1:0] seq_tab [etc_pkg::NSEQ];
    etc_pkg::etc_state_t state;
    etc_pkg::etc_desc_t cur;
    logic [etc_pkg::IW-1:0] cur_idx;
    logic [etc_pkg::CHW-1:0] cur_ch;
    logic seq_run;
    logic seq_first;
    logic [etc_pkg::SELW-1:0] sel;
    logic [etc_pkg::IW-1:0] resume_ptr;
    logic resume_valid;
    logic [etc_pkg::CHW-1:0] pick_ch;
    logic any_req;
    logic is_seq;
    logic rd_done;
    logic wr_done;
    logic [31:0] next_src;
    logic [31:0] next_dst;
    logic [8:0] next_left;
    logic unit_end;
    logic [etc_pkg::IW-1:0] next_idx;
    logic chain_go;
    logic pause;
    logic f_in_ready;
    logic f_out_valid;
    logic [etc_pkg::DW-1:0] f_out_data;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Lowest numbered pending channel wins.
    function automatic logic [etc_pkg::CHW-1:0] lowest(input logic [etc_pkg::NCH-1:0] r);
        logic [etc_pkg::CHW-1:0] n;
        n = '0;
        for (int i = etc_pkg::NCH - 1; i >= 0; i--) begin
            if (r[i]) begin
                n = i[etc_pkg::CHW-1:0];
            end
        end
        return n;
    endfunction : lowest

    // Address step for one data unit.
    function automatic logic [31:0] step(input logic [1:0] sz, input logic inc);
        logic [31:0] s;
        s = etc_pkg::STEP_NONE;
        if (inc) begin
            case (sz)
                etc_pkg::SZ_BYTE: s = etc_pkg::STEP_BYTE;
                etc_pkg::SZ_WORD: s = etc_pkg::STEP_WORD;
                default: s = etc_pkg::STEP_LONG;
            endcase
        end
        return s;
    endfunction : step

    assign pick_ch = lowest(act_req);
    assign any_req = |act_req;
    // A single source number can own the sequence feature at once.
    assign is_seq = seq_en && (pick_ch == seq_src_ch);
    assign rd_done = (state == etc_pkg::ST_READ) && bus_ack;
    assign wr_done = (state == etc_pkg::ST_WRITE) && bus_ack;
    assign busy = (state != etc_pkg::ST_IDLE);

    // ------------------------------------------------------------------
    // Data path through the buffer
    // ------------------------------------------------------------------
    // Reads are only issued while the buffer has room, so a stalled
    // write side holds the engine back instead of dropping data.
    assign bus_req = ((state == etc_pkg::ST_READ) && f_in_ready)
        || ((state == etc_pkg::ST_WRITE) && f_out_valid);
    assign bus_cmd.we = (state == etc_pkg::ST_WRITE);
    assign bus_cmd.size = cur.size;
    assign bus_cmd.addr = (state == etc_pkg::ST_WRITE) ? cur.dst : cur.src;
    assign bus_cmd.wdata = f_out_data;

    etc_fifo #(.WIDTH(etc_pkg::DW), .DEPTH(etc_pkg::FIFO_DEPTH)) etc_fifo_inst (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(rd_done),
        .in_ready(f_in_ready),
        .in_data(bus_rdata),
        .out_valid(f_out_valid),
        .out_ready(wr_done),
        .out_data(f_out_data)
    );

    // ------------------------------------------------------------------
    // Address, repeat and count update after each write
    // ------------------------------------------------------------------
    // Repeat and block share one down counter; in block mode it marks the
    // block end, and in both modes it brings the repeating side back.
    always_comb begin
        next_src = cur.src + step(cur.size, cur.src_inc);
        next_dst = cur.dst + step(cur.size, cur.dst_inc);
        next_left = cur.rpt_left - etc_pkg::RPT_ONE;
        unit_end = (cur.mode != etc_pkg::MODE_BLOCK) || (next_left == '0);
        if ((cur.mode != etc_pkg::MODE_NORMAL) && (next_left == '0)) begin
            next_left = cur.rpt;
            if (cur.rpt_dst) begin
                next_dst = cur.rpt_start;
            end else begin
                next_src = cur.rpt_start;
            end
        end
    end

    // ------------------------------------------------------------------
    // Chain and sequence decision
    // ------------------------------------------------------------------
    always_comb begin
        next_idx = cur_idx + etc_pkg::IDX_ONE;
        chain_go = cur.chain && (!cur.chain_zero || (cur.count == etc_pkg::CNT_ZERO));
        if (seq_first) begin
            next_idx = seq_tab[sel];
            chain_go = 1'b1;
        end
        pause = seq_run && !seq_first && cur.div && chain_go;
    end

    // ------------------------------------------------------------------
    // Description pool and sequence table
    // ------------------------------------------------------------------
    // The engine write-back wins; a load in the same cycle is lost, so
    // software must not rewrite a description of a running channel.
    always_ff @(posedge mclk) begin
        if (state == etc_pkg::ST_DONE) begin
            pool[cur_idx] <= cur;
        end else if (cfg_we) begin
            pool[cfg_idx] <= cfg_desc;
        end
    end

    always_ff @(posedge mclk) begin
        if (seq_we) begin
            seq_tab[seq_idx] <= seq_ptr;
        end
    end

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state <= etc_pkg::ST_IDLE;
            cur <= '0;
            cur_idx <= '0;
            cur_ch <= '0;
            seq_run <= 1'b0;
            seq_first <= 1'b0;
            sel <= '0;
            resume_ptr <= '0;
            resume_valid <= 1'b0;
        end else begin
            case (state)
                etc_pkg::ST_IDLE: begin
                    if (any_req) begin
                        cur_ch <= pick_ch;
                        // Channel number doubles as its home description.
                        cur_idx <= {{(etc_pkg::IW - etc_pkg::CHW){1'b0}}, pick_ch};
                        seq_run <= is_seq;
                        seq_first <= is_seq && !resume_valid;
                        if (is_seq && resume_valid) begin
                            cur_idx <= resume_ptr;
                        end
                        state <= etc_pkg::ST_LOAD;
                    end
                end
                etc_pkg::ST_LOAD: begin
                    cur <= pool[cur_idx];
                    state <= etc_pkg::ST_READ;
                end
                etc_pkg::ST_READ: begin
                    if (rd_done) begin
                        if (seq_first && ((cur.mode != etc_pkg::MODE_BLOCK)
                            || (cur.rpt_left == cur.rpt))) begin // First unit only.
                            sel <= bus_rdata[etc_pkg::SELW-1:0];
                        end
                        state <= etc_pkg::ST_WRITE;
                    end
                end
                etc_pkg::ST_WRITE: begin
                    if (wr_done) begin
                        cur.src <= next_src;
                        cur.dst <= next_dst;
                        cur.rpt_left <= next_left;
                        if (unit_end) begin
                            cur.count <= cur.count - etc_pkg::CNT_ONE;
                            state <= etc_pkg::ST_DONE;
                        end else begin
                            state <= etc_pkg::ST_READ;
                        end
                    end
                end
                etc_pkg::ST_DONE: begin
                    seq_first <= 1'b0;
                    if (pause) begin
                        resume_ptr <= next_idx;
                        resume_valid <= 1'b1;
                        state <= etc_pkg::ST_IDLE;
                    end else if (chain_go) begin
                        cur_idx <= next_idx;
                        state <= etc_pkg::ST_LOAD;
                    end else begin
                        if (seq_run) begin
                            resume_valid <= 1'b0;
                        end
                        state <= etc_pkg::ST_IDLE;
                    end
                end
                default: state <= etc_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Acknowledge and events
    // ------------------------------------------------------------------
    // The acknowledge follows the acceptance cycle; the requester keeps
    // its level up until then and drops it in answer.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            act_ack <= '0;
        end else begin
            act_ack <= '0;
            if ((state == etc_pkg::ST_IDLE) && any_req) begin
                act_ack[pick_ch] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            link_evt <= 1'b0;
            cpu_irq <= 1'b0;
            irq_ch <= '0;
        end else begin
            link_evt <= (state == etc_pkg::ST_DONE);
            cpu_irq <= (state == etc_pkg::ST_DONE) && cur.irq_en
                && (cur.count == etc_pkg::CNT_ZERO);
            if (state == etc_pkg::ST_DONE) begin
                irq_ch <= cur_ch;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_wr;
        state == etc_pkg::ST_WRITE && bus_ack;
    endsequence

    ack_accept_a: assert property (@(posedge mclk) disable iff (!resetn)
        |act_ack |-> $onehot(act_ack) && $past(state) == etc_pkg::ST_IDLE
            && state == etc_pkg::ST_LOAD)
        else $error("acknowledge without acceptance");
    normal_once_a: assert property (@(posedge mclk) disable iff (!resetn)
        s_wr and (cur.mode == etc_pkg::MODE_NORMAL) |=> state == etc_pkg::ST_DONE)
        else $error("normal mode did not end after one transfer");
    repeat_reload_a: assert property (@(posedge mclk) disable iff (!resetn)
        s_wr and (cur.mode == etc_pkg::MODE_REPEAT && cur.rpt_left == etc_pkg::RPT_ONE
            && !cur.rpt_dst) |=> cur.src == $past(cur.rpt_start)
            && cur.rpt_left == $past(cur.rpt))
        else $error("repeat area not reloaded");
    block_loop_a: assert property (@(posedge mclk) disable iff (!resetn)
        s_wr and (cur.mode == etc_pkg::MODE_BLOCK && cur.rpt_left > etc_pkg::RPT_ONE)
            |=> state == etc_pkg::ST_READ ##0 bus_req ##[1:300] state == etc_pkg::ST_WRITE)
        else $error("block ended early");
    count_dec_a: assert property (@(posedge mclk) disable iff (!resetn)
        s_wr and (cur.mode != etc_pkg::MODE_BLOCK) |=> cur.count == $past(cur.count) - 16'h0001)
        else $error("count not decremented");
    link_event_a: assert property (@(posedge mclk) disable iff (!resetn)
        link_evt |-> $past(state) == etc_pkg::ST_DONE ##1 !link_evt)
        else $error("link event without transfer end");
    irq_done_a: assert property (@(posedge mclk) disable iff (!resetn)
        cpu_irq |-> $past(cur.count) == 16'h0000 && $past(cur.irq_en) && irq_ch == $past(cur_ch))
        else $error("interrupt before count done");
    chain_next_a: assert property (@(posedge mclk) disable iff (!resetn)
        state == etc_pkg::ST_DONE && !seq_run && cur.chain && !cur.chain_zero
            |=> state == etc_pkg::ST_LOAD && cur_idx == $past(cur_idx) + 5'h01)
        else $error("chain did not follow");
    seq_pick_a: assert property (@(posedge mclk) disable iff (!resetn)
        state == etc_pkg::ST_DONE && seq_first |=> state == etc_pkg::ST_LOAD
            && cur_idx == $past(seq_tab[sel]))
        else $error("sequence not chosen by first data");
endmodule : etc_top
`default_nettype wire

// ### dv/etc_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module etc_bus_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // System bus slave side
    input wire logic bus_req,
    input wire etc_pkg::etc_bus_cmd_t bus_cmd,
    output logic bus_ack,
    output logic [31:0] bus_rdata,
    // Stall length in cycles
    input wire logic [3:0] wait_cyc
);
    // ------------------------------------------------------------------
    // Memory and stall state
    // ------------------------------------------------------------------
    logic [31:0] mem [0:255];
    logic [3:0] cnt = 4'h0;
    logic [31:0] last = 32'h0;
    logic hit;

    assign hit = resetn && bus_req && (cnt >= wait_cyc);

    // Answers are launched on the falling edge; idle data is the inverse of the last word.
    always @(negedge mclk) begin
        bus_ack <= hit;
        bus_rdata <= hit ? mem[bus_cmd.addr[9:2]] : ~last;
    end

    // Count stall cycles and store write data when an access completes.
    always @(posedge mclk) begin
        cnt <= (bus_req && !bus_ack) ? cnt + 4'h1 : 4'h0;
        if (bus_req && bus_ack) begin
            last <= bus_rdata;
            if (bus_cmd.we)
                mem[bus_cmd.addr[9:2]] <= bus_cmd.wdata;
        end
    end
endmodule : etc_bus_model
`default_nettype wire

// ### dv/tb_event_triggered_transfer_controller.sv
`timescale 1ns/1ns
`default_nettype none
module tb_event_triggered_transfer_controller;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic mclk = 1'b0, resetn = 1'b0, cfg_we = 1'b0, seq_we = 1'b0, seq_en = 1'b0;
    logic [7:0] act_req = 8'h00, act_ack;
    logic [4:0] cfg_idx = 5'h00, seq_ptr = 5'h00;
    logic [7:0] seq_idx = 8'h00;
    logic [2:0] seq_src_ch = 3'h0, irq_ch, irq_seen;
    etc_pkg::etc_desc_t cfg_desc = '0;
    etc_pkg::etc_bus_cmd_t bus_cmd;
    logic bus_req, bus_ack, cpu_irq, link_evt, busy;
    logic [31:0] bus_rdata;
    logic [3:0] wait_cyc = 4'h0;
    logic [1:0] wsize = 2'h3;
    int err_total = 0, compares = 0, n_link = 0, n_irq = 0;

    etc_top etc_top_inst (.mclk(mclk), .resetn(resetn), .act_req(act_req), .act_ack(act_ack),
        .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_desc(cfg_desc), .seq_we(seq_we),
        .seq_idx(seq_idx), .seq_ptr(seq_ptr), .seq_en(seq_en), .seq_src_ch(seq_src_ch),
        .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
        .cpu_irq(cpu_irq), .irq_ch(irq_ch), .link_evt(link_evt), .busy(busy));
    etc_bus_model etc_bus_model_inst (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
        .bus_cmd(bus_cmd), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .wait_cyc(wait_cyc));

    // Clock of 40 ns period.
    initial begin
        forever #20 mclk = ~mclk;
    end

    // Count event pulses, each one cycle long, and note the size of every finished write.
    always @(posedge mclk) begin
        if (bus_req === 1'b1 && bus_ack === 1'b1 && bus_cmd.we === 1'b1) wsize = bus_cmd.size;
        if (resetn && link_evt === 1'b1) n_link++;
        if (resetn && cpu_irq === 1'b1) begin
            n_irq++;
            irq_seen = irq_ch;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] iv(input int i);
        return {16'hA5C3, i[15:0]};
    endfunction : iv

    function automatic etc_pkg::etc_desc_t mk(input logic [1:0] sz, input logic [31:0] s, d,
                                              input logic [15:0] c);
        etc_pkg::etc_desc_t x;
        x = '0;
        x.size = sz;
        x.src = s;
        x.dst = d;
        x.rpt_start = s;
        x.count = c;
        x.irq_en = 1'b1;
        x.src_inc = 1'b1;
        x.dst_inc = 1'b1;
        x.rpt = etc_pkg::RPT_ONE;
        x.rpt_left = etc_pkg::RPT_ONE;
        return x;
    endfunction : mk

    task automatic close_out;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic load(input int idx, input etc_pkg::etc_desc_t d);
        @(negedge mclk);
        cfg_we = 1'b1;
        cfg_idx = idx[4:0];
        cfg_desc = d;
        @(negedge mclk);
        cfg_we = 1'b0;
    endtask : load

    function automatic logic [31:0] rd(input logic [31:0] a);
        return etc_bus_model_inst.mem[a[9:2]];
    endfunction : rd

    // Raise one request, hold it until acknowledged, then wait for idle.
    task automatic act(input int ch);
        int i;
        @(negedge mclk);
        act_req[ch] = 1'b1;
        for (i = 0; i < 50 && act_ack[ch] !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (i == 50) begin
            err_total++;
            close_out();
        end
        @(negedge mclk);
        act_req[ch] = 1'b0;
        for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge mclk);
        if (i == 3000) begin
            err_total++;
            close_out();
        end
        repeat (3) @(posedge mclk);
        #1;
    endtask : act

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_sizes;
        logic [31:0] m [0:2];
        int k, l0, i0;
        m = '{32'h0000_00FF, 32'h0000_FFFF, 32'hFFFF_FFFF};
        for (k = 0; k < 3; k++) begin
            l0 = n_link;
            i0 = n_irq;
            load(0, mk(k[1:0], 32'h4 * k, 32'h200 + 32'h4 * k, etc_pkg::CNT_ONE));
            act(0);
            chk(rd(32'h200 + 32'h4 * k) & m[k], iv(k) & m[k]);
            chk(32'(n_link - l0), 32'h1);
            chk(32'(n_irq - i0), 32'h1);
            chk(32'(irq_seen), 32'h0);
            chk(32'(wsize), 32'(k));
        end
    endtask : t_sizes

    task automatic t_repeat;
        etc_pkg::etc_desc_t d;
        d = mk(etc_pkg::SZ_LONG, 32'h40, 32'h300, 16'h0003);
        d.mode = etc_pkg::MODE_REPEAT;
        d.rpt = 9'h002;
        d.rpt_left = 9'h002;
        load(1, d);
        repeat (3) act(1);
        chk(rd(32'h300), iv(16));
        chk(rd(32'h304), iv(17));
        chk(rd(32'h308), iv(16));
    endtask : t_repeat

    task automatic t_block;
        etc_pkg::etc_desc_t d;
        int k, l0;
        d = mk(etc_pkg::SZ_LONG, 32'h100, 32'h380, etc_pkg::CNT_ONE);
        d.mode = etc_pkg::MODE_BLOCK;
        d.rpt = 9'h004;
        d.rpt_left = 9'h004;
        load(2, d);
        wait_cyc = 4'h3;
        l0 = n_link;
        act(2);
        wait_cyc = 4'h0;
        for (k = 0; k < 4; k++) chk(rd(32'h380 + 4 * k), iv(64 + k));
        chk(rd(32'h390), iv(228));
        chk(32'(n_link - l0), 32'h1);
        chk(32'(irq_seen), 32'h2);
    endtask : t_block

    task automatic t_chain;
        etc_pkg::etc_desc_t d;
        int i0;
        d = mk(etc_pkg::SZ_LONG, 32'h20, 32'h280, etc_pkg::CNT_ONE);
        d.chain = 1'b1;
        load(3, d);
        load(4, mk(etc_pkg::SZ_LONG, 32'h24, 32'h284, etc_pkg::CNT_ONE));
        act(3);
        chk(rd(32'h280), iv(8));
        chk(rd(32'h284), iv(9));
        d = mk(etc_pkg::SZ_LONG, 32'h28, 32'h288, 16'h0002);
        d.chain = 1'b1;
        d.chain_zero = 1'b1;
        d.src_inc = 1'b0;
        d.dst_inc = 1'b0;
        load(6, d);
        load(7, mk(etc_pkg::SZ_LONG, 32'h2C, 32'h290, etc_pkg::CNT_ONE));
        i0 = n_irq;
        act(6);
        chk(rd(32'h290), iv(164));
        chk(32'(n_irq - i0), 32'h0);
        act(6);
        chk(rd(32'h290), iv(11));
    endtask : t_chain

    task automatic t_seq;
        etc_pkg::etc_desc_t d;
        etc_bus_model_inst.mem[12] = 32'h0000_0009;
        load(5, mk(etc_pkg::SZ_LONG, 32'h30, 32'h2A0, etc_pkg::CNT_ONE));
        d = mk(etc_pkg::SZ_LONG, 32'h34, 32'h2A4, etc_pkg::CNT_ONE);
        d.chain = 1'b1;
        d.div = 1'b1;
        load(10, d);
        load(11, mk(etc_pkg::SZ_LONG, 32'h38, 32'h2A8, etc_pkg::CNT_ONE));
        @(negedge mclk);
        seq_we = 1'b1;
        seq_idx = 8'h09;
        seq_ptr = 5'h0A;
        seq_en = 1'b1;
        seq_src_ch = 3'h5;
        @(negedge mclk);
        seq_we = 1'b0;
        act(5);
        chk(rd(32'h2A0), 32'h0000_0009);
        chk(rd(32'h2A4), iv(13));
        chk(rd(32'h2A8), iv(170));
        act(5);
        chk(rd(32'h2A8), iv(14));
        @(negedge mclk);
        seq_en = 1'b0;
    endtask : t_seq

    // A block as long as the buffer is deep, with stalls, through the whole engine.
    task automatic t_fifo;
        etc_pkg::etc_desc_t d;
        int k, l0, i0;
        d = mk(etc_pkg::SZ_LONG, 32'h180, 32'h3C0, etc_pkg::CNT_ONE);
        d.mode = etc_pkg::MODE_BLOCK;
        d.rpt = 9'h010;
        d.rpt_left = 9'h010;
        load(4, d);
        wait_cyc = 4'h2;
        l0 = n_link;
        i0 = n_irq;
        act(4);
        wait_cyc = 4'h0;
        for (k = 0; k < 16; k++) chk(rd(32'h3C0 + 4 * k), iv(96 + k));
        chk(32'(n_link - l0), 32'h1);
        chk(32'(n_irq - i0), 32'h1);
        chk(32'(irq_seen), 32'h4);
        chk(32'(wsize), 32'(etc_pkg::SZ_LONG));
    endtask : t_fifo

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 256; i++) etc_bus_model_inst.mem[i] = iv(i);
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        chk(32'(busy), 32'h0);
        t_sizes();
        t_repeat();
        t_block();
        t_chain();
        t_seq();
        t_fifo();
        close_out();
    end
endmodule : tb_event_triggered_transfer_controller
`default_nettype wire
